// ===== dcd_irq.sv
// Purpose: Sticky event status, mask and level interrupt
// Assumes: Clear is write-one-to-clear from the register port
// Notes: An event in the clearing cycle keeps its bit set
`timescale 1ns/1ps
module dcd_irq
    import dcd_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [NIRQ-1:0] ev,
    input wire logic [NIRQ-1:0] clr,
    input wire logic mask_we,
    input wire logic [NIRQ-1:0] mask_wd,
    output logic [NIRQ-1:0] stat,
    output logic [NIRQ-1:0] mask,
    output logic irq
);
    typedef struct packed {
        logic [NIRQ-1:0] stat;
        logic [NIRQ-1:0] mask;
        logic irq;
    } dcd_irq_s;

    dcd_irq_s r;
    dcd_irq_s n;

    always_comb
    begin
        n = r;
        // Set beats clear
        n.stat = ev | (r.stat & ~clr);
        if (mask_we)
        begin
            n.mask = mask_wd;
        end
        n.irq = |(n.stat & n.mask);
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            r <= '0;
        end
        else
        begin
            r <= n;
        end
    end

    assign stat = r.stat;
    assign mask = r.mask;
    assign irq = r.irq;
endmodule : dcd_irq

// ===== dcd_mem_model.sv
// Purpose: Memory and peripheral space behind the channel
// Assumes: Byte accesses, lat wait cycles per access
// Notes: Read byte is a function of address; writes are logged
`timescale 1ns/1ps
module dcd_mem_model
    import dcd_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire dcd_pkg::dcd_mem_req_s mem_req,
    input wire logic [1:0] lat,
    output logic [7:0] mem_rdata,
    output logic mem_waitrequest
);
    logic [1:0] wait_r = 2'h0;
    logic [7:0] tick_r = 8'h00;
    logic [31:0] wa[$];
    logic [7:0] wd[$];
    logic busy;
    assign busy = mem_req.rd | mem_req.wr;
    assign mem_waitrequest = busy && (wait_r < lat);
    // Idle bus shows a moving pattern, never the last byte
    assign mem_rdata = mem_req.rd ? (mem_req.addr[7:0] ^ 8'h5A) : tick_r;
    always @(posedge clk)
    begin
        tick_r <= tick_r + 8'h3B;
        if (!rstn || !mem_waitrequest)
            wait_r <= 2'h0;
        else
            wait_r <= wait_r + 2'h1;
        if (rstn && mem_req.wr && !mem_waitrequest)
        begin
            wa.push_back(mem_req.addr);
            wd.push_back(mem_req.wdata);
        end
    end
endmodule : dcd_mem_model

// ===== dcd_pkg.sv
// Purpose: Shared constants and types for the descriptor-driven DMA channel
// Assumes: 40 MHz bus clock, byte-addressed Avalon-MM register port
// Notes: Register words are 32-bit aligned; unmapped offsets read zero
package dcd_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NTD = 4;
    localparam int TDW = 2;
    localparam int BLW = 7;
    localparam int CNTW = 12;
    localparam int NIRQ = 2;
    localparam int DONE_CYC = 2;

    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_AHI = 8'h04;
    localparam logic [7:0] A_STAT = 8'h08;
    localparam logic [7:0] A_ISTAT = 8'h0C;
    localparam logic [7:0] A_IMASK = 8'h10;
    localparam logic [7:0] A_TD0 = 8'h20;
    localparam logic [7:0] A_TDEND = 8'h40;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int C_EN = 0;
    localparam int C_PRES = 1;
    localparam int C_RPB = 2;
    localparam int C_BL = 8;
    localparam int C_INIT = 16;
    localparam int AHI_DST = 16;
    localparam int W0_DST = 16;
    localparam int W1_NXT = 16;
    localparam int W1_STOP = 18;
    localparam int W1_ISRC = 24;
    localparam int W1_IDST = 25;
    localparam int W1_DONE = 26;
    localparam int W1_AUTO = 27;
    localparam int S_PEND = 8;
    localparam int S_LOAD = 9;
    localparam int S_CUR = 12;
    localparam int I_DONE = 0;
    localparam int I_STOP = 1;
    localparam logic [31:0] CTRL_MASK = 32'h00037F07;
    localparam logic [BLW-1:0] BL_RST = 7'h01;

    typedef struct packed {
        logic auto_next;
        logic done_en;
        logic inc_dst;
        logic inc_src;
        logic stop;
        logic [TDW-1:0] nxt;
        logic [CNTW-1:0] cnt;
        logic [15:0] dst_lo;
        logic [15:0] src_lo;
    } dcd_desc_s;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [31:0] addr;
        logic [7:0] wdata;
    } dcd_mem_req_s;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_LOAD = 5'b00010,
        ST_RD = 5'b00100,
        ST_WR = 5'b01000,
        ST_END = 5'b10000
    } dcd_state_e;
endpackage : dcd_pkg

// ===== dcd_props.sv
// Purpose: Port checks of the DMA channel
// Assumes: Register writes use all byte lanes
// Notes: Bound to every dcd_top
`timescale 1ns/1ps
module dcd_props
    import dcd_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic drq,
    input wire dcd_pkg::dcd_mem_req_s mem_req,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_waitrequest,
    input wire logic done,
    input wire logic irq
);
    logic [31:0] ahi_r;
    logic rg;
    logic wg;
    assign rg = mem_req.rd && !mem_waitrequest;
    assign wg = mem_req.wr && !mem_waitrequest;
    default clocking dcd_cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    // Shadow of upper address halves
    always_ff @(posedge clk)
    begin
        if (!rstn)
            ahi_r <= 32'h0;
        else if (avs_write && !avs_waitrequest && avs_address == A_AHI)
            ahi_r <= avs_writedata;
    end
    AST_DONE_WIDTH: assert property ($rose(done) |=> done ##1 !done)
        else $error("done pulse not two cycles");
    AST_DONE_CAUSE: assert property ($rose(done) |-> $past(wg, 2) || $past(wg, 3) || $past(wg, 4))
        else $error("done without a final write");
    AST_WDATA: assert property (rg |=> mem_req.wr && mem_req.wdata == $past(mem_rdata))
        else $error("write does not carry the byte read");
    AST_RD_HOLD: assert property (mem_req.rd && mem_waitrequest |=> mem_req.rd && $stable(mem_req.addr))
        else $error("read request dropped while stalled");
    AST_WR_HOLD: assert property (mem_req.wr && mem_waitrequest |=> mem_req.wr && $stable(mem_req))
        else $error("write request changed while stalled");
    AST_ONE_DIR: assert property (!(mem_req.rd && mem_req.wr))
        else $error("read and write together");
    AST_SRC_HI: assert property (mem_req.rd |-> mem_req.addr[31:16] == ahi_r[15:0])
        else $error("source upper half wrong");
    AST_DST_HI: assert property (mem_req.wr |-> mem_req.addr[31:16] == ahi_r[31:16])
        else $error("destination upper half wrong");
    AST_AVS_ANS: assert property ($rose(avs_read || avs_write) |=> !avs_waitrequest)
        else $error("register answer late");
    AST_AVS_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    cover property ($rose(done));
    cover property (mem_req.rd && mem_waitrequest);
    cover property ($rose(irq));
endmodule : dcd_props

bind dcd_top dcd_props dcd_props_i(.clk(clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .drq(drq), .mem_req(mem_req), .mem_rdata(mem_rdata),
    .mem_waitrequest(mem_waitrequest), .done(done), .irq(irq));

// ===== dcd_pulse.sv
// Purpose: Stretch a one-cycle trigger into the fixed-width done pulse
// Assumes: Triggers are at least DONE_CYC cycles apart
// Notes: Output comes straight from a flop
`timescale 1ns/1ps
module dcd_pulse
    import dcd_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic trig,
    output logic pulse
);
    typedef struct packed {
        logic [1:0] cnt;
        logic pulse;
    } dcd_pulse_s;

    dcd_pulse_s r;
    dcd_pulse_s n;

    always_comb
    begin
        n = r;
        if (trig)
        begin
            n.cnt = 2'(DONE_CYC);
        end
        else if (r.cnt != 2'h0)
        begin
            n.cnt = 2'(r.cnt - 2'h1);
        end
        n.pulse = (n.cnt != 2'h0);
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            r <= '0;
        end
        else
        begin
            r <= n;
        end
    end

    assign pulse = r.pulse;
endmodule : dcd_pulse

// ===== dcd_top.sv
// Purpose: One DMA channel moving bytes in bursts along a descriptor chain
// Assumes: drq synchronous to clk; memory port is a simple wait-state master
// Notes: Registers over Avalon-MM; done pulse and irq from sub-blocks
//
// Function
// - Upper 16 address bits of source and destination come from channel configuration
// - Lower 16 address bits come from the active transfer_descriptor
// - One-byte burst: each request reads one source byte, writes it to destination
// - Request-per-burst set: one burst per request, then wait for a fresh one
// - Request-per-burst clear: first burst needs request, later bursts run automatically
// - Descriptor linked to itself with preserve set and auto-next clear repeats the same transfer on each new request
// - Preserve set: originals untouched, working copy reloaded for each run
// - Preserve clear: descriptor storage itself is updated as work proceeds
// - Destination increment advances destination by burst length; source increment advances source the same way
// - Count drops by burst length per burst until it reaches zero
// - Count reaching zero with completion enabled raises transfer-complete output
// - Transfer-complete is a single pulse two bus clocks wide
// - Requests are acted on only while channel is enabled
//
// The Avalon-MM register port and the address map were left to the implementer.
`timescale 1ns/1ps
module dcd_top
    import dcd_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic drq,
    output dcd_pkg::dcd_mem_req_s mem_req,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_waitrequest,
    output logic done,
    output logic irq
);
    import dcd_pkg::*;

    typedef struct packed {
        dcd_state_e st;
        logic ack;
        logic wrq;
        logic [31:0] rdata;
        logic [31:0] ctrl;
        logic [31:0] ahi;
        dcd_desc_s [NTD-1:0] td;
        logic [TDW-1:0] cur;
        logic loaded;
        logic cont;
        logic pend;
        logic drq_q;
        logic en_q;
        logic [15:0] w_src;
        logic [15:0] w_dst;
        logic [CNTW-1:0] w_cnt;
        logic [BLW-1:0] idx;
        dcd_mem_req_s mem;
        logic fire;
        logic stop_ev;
    } dcd_top_s;

    dcd_top_s r;
    dcd_top_s n;

    logic [NIRQ-1:0] istat;
    logic [NIRQ-1:0] imask;
    logic [NIRQ-1:0] iclr;
    logic imask_we;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] be_merge(logic [31:0] old, logic [31:0] wd,
                                             logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
        begin
            if (be[b])
            begin
                res[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return res;
    endfunction : be_merge

    function automatic logic [31:0] td_w1(dcd_desc_s d);
        logic [31:0] w;
        w = '0;
        w[CNTW-1:0] = d.cnt;
        w[W1_NXT +: TDW] = d.nxt;
        w[W1_STOP] = d.stop;
        w[W1_ISRC] = d.inc_src;
        w[W1_IDST] = d.inc_dst;
        w[W1_DONE] = d.done_en;
        w[W1_AUTO] = d.auto_next;
        return w;
    endfunction : td_w1

    function automatic dcd_desc_s td_set_w1(dcd_desc_s d, logic [31:0] w);
        dcd_desc_s o;
        o = d;
        o.cnt = w[CNTW-1:0];
        o.nxt = w[W1_NXT +: TDW];
        o.stop = w[W1_STOP];
        o.inc_src = w[W1_ISRC];
        o.inc_dst = w[W1_IDST];
        o.done_en = w[W1_DONE];
        o.auto_next = w[W1_AUTO];
        return o;
    endfunction : td_set_w1

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        logic acc;
        logic wr;
        logic rd;
        logic [7:0] off;
        logic [TDW-1:0] sel;
        logic hit_td;
        logic en;
        logic rpb;
        logic pres;
        logic [BLW-1:0] blen;
        logic [BLW-1:0] step;
        logic [CNTW-1:0] left;
        logic take;
        logic edge_q;
        dcd_desc_s d;

        n = r;
        n.fire = 1'b0;
        n.stop_ev = 1'b0;
        iclr = '0;
        imask_we = 1'b0;
        take = 1'b0;

        acc = (avs_read | avs_write) & ~r.ack;
        // Commit on the edge at which the master sees waitrequest low
        wr = avs_write & r.ack;
        rd = acc & avs_read;
        n.ack = acc;
        n.wrq = ~acc;
        off = 8'(avs_address - A_TD0);
        sel = off[3 +: TDW];
        hit_td = (avs_address >= A_TD0) && (avs_address < A_TDEND);

        // Register writes
        if (wr)
        begin
            if (avs_address == A_CTRL)
            begin
                n.ctrl = be_merge(r.ctrl, avs_writedata, avs_byteenable) & CTRL_MASK;
            end
            else if (avs_address == A_AHI)
            begin
                n.ahi = be_merge(r.ahi, avs_writedata, avs_byteenable);
            end
            else if (avs_address == A_ISTAT)
            begin
                iclr = avs_writedata[NIRQ-1:0] & {NIRQ{avs_byteenable[0]}};
            end
            else if (avs_address == A_IMASK)
            begin
                imask_we = avs_byteenable[0];
            end
            else if (hit_td && !off[2])
            begin
                n.td[sel][31:0] = be_merge(r.td[sel][31:0], avs_writedata, avs_byteenable);
            end
            else if (hit_td)
            begin
                n.td[sel] = td_set_w1(r.td[sel],
                                      be_merge(td_w1(r.td[sel]), avs_writedata,
                                               avs_byteenable));
            end
        end

        // Register reads
        if (rd)
        begin
            n.rdata = '0;
            if (avs_address == A_CTRL)
            begin
                n.rdata = r.ctrl;
            end
            else if (avs_address == A_AHI)
            begin
                n.rdata = r.ahi;
            end
            else if (avs_address == A_STAT)
            begin
                n.rdata[4:0] = r.st;
                n.rdata[S_PEND] = r.pend;
                n.rdata[S_LOAD] = r.loaded;
                n.rdata[S_CUR +: TDW] = r.cur;
            end
            else if (avs_address == A_ISTAT)
            begin
                n.rdata[NIRQ-1:0] = istat;
            end
            else if (avs_address == A_IMASK)
            begin
                n.rdata[NIRQ-1:0] = imask;
            end
            else if (hit_td && !off[2])
            begin
                n.rdata = r.td[sel][31:0];
            end
            else if (hit_td)
            begin
                n.rdata = td_w1(r.td[sel]);
            end
        end

        en = r.ctrl[C_EN];
        rpb = r.ctrl[C_RPB];
        pres = r.ctrl[C_PRES];
        blen = (r.ctrl[C_BL +: BLW] == '0) ? BL_RST : r.ctrl[C_BL +: BLW];
        d = r.td[r.cur];
        step = 7'(r.idx + 7'h01);
        left = 12'(r.w_cnt - {5'h0, step});

        // Fresh enable restarts the chain at the initial descriptor
        n.en_q = en;
        if (en && !r.en_q)
        begin
            n.cur = r.ctrl[C_INIT +: TDW];
            n.loaded = 1'b0;
            n.cont = 1'b0;
        end

        // ------------------------------------------------------------
        // Channel sequencer
        // ------------------------------------------------------------
        case (r.st)
            ST_IDLE:
            begin
                if (en && r.en_q && (r.pend || (r.cont && !rpb)))
                begin
                    take = !(r.cont && !rpb);
                    n.idx = '0;
                    if (r.loaded)
                    begin
                        n.st = ST_RD;
                        n.mem = '{1'b1, 1'b0, {r.ahi[15:0], r.w_src}, 8'h00};
                    end
                    else
                    begin
                        n.st = ST_LOAD;
                    end
                end
            end
            ST_LOAD:
            begin
                n.w_src = d.src_lo;
                n.w_dst = d.dst_lo;
                n.w_cnt = d.cnt;
                n.idx = '0;
                if (d.cnt == '0)
                begin
                    // Spent descriptor: nothing to move, park the channel
                    n.st = ST_IDLE;
                    n.ctrl[C_EN] = 1'b0;
                    n.stop_ev = 1'b1;
                end
                else
                begin
                    n.loaded = 1'b1;
                    n.st = ST_RD;
                    n.mem = '{1'b1, 1'b0, {r.ahi[15:0], d.src_lo}, 8'h00};
                end
            end
            ST_RD:
            begin
                if (!mem_waitrequest)
                begin
                    n.st = ST_WR;
                    n.mem = '{1'b0, 1'b1,
                              {r.ahi[AHI_DST +: 16], 16'(r.w_dst + {9'h0, r.idx})},
                              mem_rdata};
                end
            end
            ST_WR:
            begin
                if (!mem_waitrequest)
                begin
                    n.mem = '0;
                    if ((step != blen) && ({5'h0, step} != r.w_cnt))
                    begin
                        n.idx = step;
                        n.st = ST_RD;
                        n.mem = '{1'b1, 1'b0,
                                  {r.ahi[15:0], 16'(r.w_src + {9'h0, step})}, 8'h00};
                    end
                    else
                    begin
                        if (d.inc_src)
                        begin
                            n.w_src = 16'(r.w_src + {9'h0, step});
                        end
                        if (d.inc_dst)
                        begin
                            n.w_dst = 16'(r.w_dst + {9'h0, step});
                        end
                        n.w_cnt = left;
                        if (!pres)
                        begin
                            n.td[r.cur].src_lo = n.w_src;
                            n.td[r.cur].dst_lo = n.w_dst;
                            n.td[r.cur].cnt = left;
                        end
                        n.cont = (left != '0);
                        n.st = (left == '0) ? ST_END : ST_IDLE;
                    end
                end
            end
            ST_END:
            begin
                n.fire = d.done_en;
                n.loaded = 1'b0;
                n.cont = 1'b0;
                if (d.stop)
                begin
                    n.ctrl[C_EN] = 1'b0;
                    n.stop_ev = 1'b1;
                    n.st = ST_IDLE;
                end
                else
                begin
                    // self link reruns on next request, or at once when its auto_next is set
                    n.cur = d.nxt;
                    n.st = r.td[d.nxt].auto_next ? ST_LOAD : ST_IDLE;
                end
            end
            default:
            begin
                n.st = ST_IDLE;
                n.mem = '0;
            end
        endcase

        // pending request, set wins over consume
        n.drq_q = drq;
        edge_q = drq & ~r.drq_q;
        n.pend = en & (edge_q | (r.pend & ~take));
    end

    always_ff @(posedge clk)
    begin
        if (!rstn)
        begin
            r <= '0;
            r.st <= ST_IDLE;
            r.wrq <= 1'b1;
            r.ctrl[C_BL +: BLW] <= BL_RST;
        end
        else
        begin
            r <= n;
        end
    end

    // ------------------------------------------------------------
    // Done pulse and interrupt
    // ------------------------------------------------------------
    // two-cycle pulse
    dcd_pulse u_pulse (
        .clk(clk),
        .rstn(rstn),
        .trig(r.fire),
        .pulse(done)
    );

    dcd_irq u_irq (
        .clk(clk),
        .rstn(rstn),
        .ev({r.stop_ev, r.fire}),
        .clr(iclr),
        .mask_we(imask_we),
        .mask_wd(avs_writedata[NIRQ-1:0]),
        .stat(istat),
        .mask(imask),
        .irq(irq)
    );

    assign avs_readdata = r.rdata;
    assign avs_waitrequest = r.wrq;
    assign mem_req = r.mem;
endmodule : dcd_top

// ===== dcd_top_tb_top.sv
// Purpose: Self-checking bench of the DMA channel
// Assumes: Register bus answers before the hang guard runs out
// Notes: Source bytes are address low byte xor 5A
`timescale 1ns/1ps
module dcd_top_tb_top;
    import dcd_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic drq = 1'b0;
    dcd_mem_req_s mem_req;
    logic [7:0] mem_rdata;
    logic mem_waitrequest;
    logic done;
    logic irq;
    logic [1:0] lat = 2'h0;
    logic [31:0] rd_v;
    int error_cnt = 0;
    int n_checks = 0;
    int done_cyc = 0;
    int cyc = 0;
    dcd_top dcd_top_i(.clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .drq(drq),
        .mem_req(mem_req), .mem_rdata(mem_rdata), .mem_waitrequest(mem_waitrequest),
        .done(done), .irq(irq));
    dcd_mem_model dcd_mem_model_i(.clk(clk), .rstn(rstn), .mem_req(mem_req), .lat(lat),
        .mem_rdata(mem_rdata), .mem_waitrequest(mem_waitrequest));
    initial
    begin
        forever #12.5 clk = ~clk;
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude
    // Hang guard and done width count
    always @(posedge clk)
    begin
        cyc++;
        if (done === 1'b1)
            done_cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            conclude();
        end
    end
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0)
        begin
            @(posedge clk);
        end
        rd_v = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic req();
        drq <= 1'b1;
        @(posedge clk);
        drq <= 1'b0;
        @(posedge clk);
    endtask : req
    task automatic settle(input int n);
        int k;
        k = 0;
        while (dcd_mem_model_i.wa.size() < n && k < 300)
        begin
            @(posedge clk);
            k++;
        end
        repeat (12) @(posedge clk);
    endtask : settle
    task automatic chk_wr(input int i, input logic [31:0] a, input logic [7:0] s);
        chk("write address", a, dcd_mem_model_i.wa[i]);
        chk("write data", {24'h0, s ^ 8'h5A}, {24'h0, dcd_mem_model_i.wd[i]});
    endtask : chk_wr
    task automatic t_reset();
        bus(1'b0, A_CTRL, 32'h0);
        chk("ctrl reset", 32'h100, rd_v);
        bus(1'b0, A_STAT, 32'h0);
        chk("status reset", 32'h1, rd_v);
        bus(1'b0, 8'h18, 32'h0);
        chk("unmapped", 32'h0, rd_v);
        bus(1'b1, A_AHI, 32'h40002000);
        $display("test reset done");
    endtask : t_reset
    task automatic t_loop();
        bus(1'b1, A_TD0, 32'h00100030);
        bus(1'b1, 8'h24, 32'h00000001);
        bus(1'b1, A_CTRL, 32'h00000107);
        repeat (4) @(posedge clk);
        for (int i = 0; i < 3; i++)
        begin
            req();
            settle(i + 1);
            chk("single requests", i + 1, dcd_mem_model_i.wa.size());
            chk_wr(i, 32'h40000010, 8'h30);
        end
        bus(1'b0, 8'h24, 32'h0);
        chk("kept descriptor", 32'h1, rd_v);
        chk("no done", 0, done_cyc);
        bus(1'b1, A_CTRL, 32'h0);
        $display("test loop done");
    endtask : t_loop
    task automatic t_burst();
        dcd_mem_model_i.wa.delete();
        dcd_mem_model_i.wd.delete();
        bus(1'b1, 8'h28, 32'h00500060);
        bus(1'b1, 8'h2C, 32'h06010006);
        bus(1'b1, A_CTRL, 32'h00010207);
        repeat (4) @(posedge clk);
        req();
        settle(2);
        chk("one burst", 2, dcd_mem_model_i.wa.size());
        req();
        repeat (2) @(posedge clk);
        req();
        settle(6);
        chk("pending burst", 6, dcd_mem_model_i.wa.size());
        for (int j = 0; j < 6; j++)
            chk_wr(j, 32'h40000050 + j, 8'h60 + 8'(j % 2));
        chk("done width", 2, done_cyc);
        chk("masked irq", 0, irq);
        bus(1'b0, A_ISTAT, 32'h0);
        chk("done status", 32'h1, rd_v);
        bus(1'b1, A_IMASK, 32'h1);
        chk("unmasked irq", 1, irq);
        bus(1'b1, A_ISTAT, 32'h1);
        chk("cleared irq", 0, irq);
        bus(1'b1, A_CTRL, 32'h0);
        $display("test burst done");
    endtask : t_burst
    task automatic t_auto();
        dcd_mem_model_i.wa.delete();
        dcd_mem_model_i.wd.delete();
        lat <= 2'h2;
        bus(1'b1, 8'h30, 32'h00800070);
        bus(1'b1, 8'h34, 32'h01020003);
        bus(1'b1, A_CTRL, 32'h00020100);
        req();
        settle(1);
        bus(1'b1, A_CTRL, 32'h00020101);
        repeat (12) @(posedge clk);
        chk("disabled", 0, dcd_mem_model_i.wa.size());
        req();
        settle(3);
        chk("auto bursts", 3, dcd_mem_model_i.wa.size());
        for (int j = 0; j < 3; j++)
            chk_wr(j, 32'h40000080, 8'h70 + 8'(j));
        bus(1'b0, 8'h34, 32'h0);
        chk("worked count", 32'h0, rd_v & 32'hFFF);
        // Rerun of the spent descriptor must stop the channel
        req();
        repeat (12) @(posedge clk);
        chk("no spent moves", 3, dcd_mem_model_i.wa.size());
        bus(1'b0, A_ISTAT, 32'h0);
        chk("stopped status", 32'h2, rd_v);
        bus(1'b0, A_CTRL, 32'h0);
        chk("stopped channel", 32'h00020100, rd_v);
        $display("test auto done");
    endtask : t_auto
    initial
    begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_reset();
        t_loop();
        t_burst();
        t_auto();
        conclude();
    end
endmodule : dcd_top_tb_top
